// ===== hdl/rpc_defines.svh
// register offsets, reset values, masks and field positions of the port-1 register set
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPC_OFF_LOWPWR  8'h50
`define RPC_OFF_STATUS  8'h60
`define RPC_OFF_UTX     8'h70
`define RPC_OFF_UPE     8'h71
`define RPC_OFF_URX     8'h72
`define RPC_OFF_UDS     8'h73
`define RPC_OFF_EPE     8'h77

// ----------------------------------------
// hardware reset values
// ----------------------------------------
`define RPC_RST_LOWPWR  8'h50
`define RPC_RST_STATUS  8'h00
`define RPC_RST_UTX     8'h77
`define RPC_RST_UPE     8'h39
`define RPC_RST_URX     8'h92
`define RPC_RST_UDS     8'h74
`define RPC_RST_EPE     8'h40

// ----------------------------------------
// writable bits, equal to the factory-loaded bits
// ----------------------------------------
`define RPC_MSK_LOWPWR  8'h7f
`define RPC_MSK_UTX     8'hff
`define RPC_MSK_UPE     8'h7f
`define RPC_MSK_URX     8'hc7
`define RPC_MSK_UDS     8'hf7
`define RPC_MSK_EPE     8'hf8
`define RPC_MSK_ODS     8'hc0

// ----------------------------------------
// field positions (lsb)
// ----------------------------------------
`define RPC_LP_HOST     6
`define RPC_LP_PERI     5
`define RPC_LP_RESP     4
`define RPC_BR_POL      3
`define RPC_BR_PU       2
`define RPC_BR_SRC      1
`define RPC_BR_EN       0
`define RPC_ROLE_LSB    3
`define RPC_CHG_BIT     0
`define RPC_TERM_LSB    6
`define RPC_EDGE_LSB    4
`define RPC_SWING_LSB   0
`define RPC_CHG1_BIT    6
`define RPC_BWID_LSB    4
`define RPC_BEN_BIT     3
`define RPC_BLVL_LSB    0
`define RPC_ODS_LSB     6
`define RPC_EQ_LSB      0
`define RPC_UNPLUG_LSB  4
`define RPC_SIGDET_LSB  0
`define RPC_EBLVL_LSB   5
`define RPC_EBWID_LSB   3

// ----------------------------------------
// misc constants
// ----------------------------------------
`define RPC_SWING_NOMINAL 4'h3
`define RPC_URX_RSVD      3'h2

`endif

// ===== hdl/rpc_pkg.sv
// types shared by the port-1 register set modules
package rpc_pkg;

  // register index
  typedef enum logic [2:0] {
    RPC_IX_LOWPWR = 3'h0,
    RPC_IX_UTX    = 3'h1,
    RPC_IX_UPE    = 3'h2,
    RPC_IX_URX    = 3'h3,
    RPC_IX_UDS    = 3'h4,
    RPC_IX_EPE    = 3'h5,
    RPC_IX_STATUS = 3'h6,
    RPC_IX_NONE   = 3'h7
  } rpc_reg_ix_t;

  // port role report
  typedef enum logic [1:0] {
    RPC_ROLE_NONE   = 2'h0,
    RPC_ROLE_HOST   = 2'h1,
    RPC_ROLE_PERIPH = 2'h2,
    RPC_ROLE_RSVD   = 2'h3
  } rpc_role_t;

  // factory default loader states
  typedef enum logic [1:0] {
    RPC_LD_REQ  = 2'h0,
    RPC_LD_WAIT = 2'h1,
    RPC_LD_TAKE = 2'h2,
    RPC_LD_DONE = 2'h3
  } rpc_load_state_t;

  typedef logic [7:0] rpc_byte_t;

endpackage

// ===== hdl/rpc_load_if.sv
// carrier from the factory default loader to the register set
`timescale 1ns/1ps
`default_nettype none
interface rpc_load_if;
  logic                   load_we;
  rpc_pkg::rpc_reg_ix_t   load_ix;
  rpc_pkg::rpc_byte_t     load_data;
  logic                   done;
  modport loader (output load_we, output load_ix, output load_data, output done);
  modport regs   (input  load_we, input  load_ix, input  load_data, input  done);
endinterface
`default_nettype wire

// ===== hdl/rpc_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module rpc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule // rpc_sync
`default_nettype wire

// ===== hdl/rpc_otp_loader.sv
// walks the factory memory after reset and hands defaults to the register set
`timescale 1ns/1ps
`default_nettype none
`include "rpc_defines.svh"
module rpc_otp_loader (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  output logic                      otp_rd,
  output rpc_pkg::rpc_reg_ix_t      otp_ix,
  input  wire rpc_pkg::rpc_byte_t   otp_rdata,
  input  wire logic                 otp_programmed,
  rpc_load_if.loader                ld
);
  import rpc_pkg::*;

  rpc_load_state_t st_r;
  rpc_reg_ix_t     ix_r;
  logic            rd_r;
  logic            we_r;
  rpc_byte_t       data_r;
  logic            done_r;
  wire             last_w = (ix_r == RPC_IX_EPE);

  // request, wait one cycle for data, take it, move on
  // factory defaults load
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= RPC_LD_REQ;
      ix_r   <= RPC_IX_LOWPWR;
      rd_r   <= 1'b0;
      we_r   <= 1'b0;
      data_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      we_r <= 1'b0;
      case (st_r)
        RPC_LD_REQ: begin
          rd_r <= 1'b1;
          st_r <= RPC_LD_WAIT;
        end
        RPC_LD_WAIT: begin
          rd_r <= 1'b0;
          st_r <= RPC_LD_TAKE;
        end
        RPC_LD_TAKE: begin
          we_r   <= otp_programmed;
          data_r <= otp_rdata;
          if (last_w) begin
            st_r <= RPC_LD_DONE;
          end else begin
            ix_r <= rpc_reg_ix_t'(ix_r + 3'h1);
            st_r <= RPC_LD_REQ;
          end
        end
        RPC_LD_DONE: begin
          done_r <= 1'b1;
        end
        default: begin
          st_r <= RPC_LD_DONE;
        end
      endcase
    end
  end

  assign otp_rd       = rd_r;
  assign otp_ix       = ix_r;
  assign ld.load_we   = we_r;
  assign ld.load_ix   = ix_r;
  assign ld.load_data = data_r;
  assign ld.done      = done_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence rd_pulse_s;
    rd_r ##1 !rd_r ##1 !rd_r;
  endsequence

  ld_pulse_a: assert property (rd_r |-> rd_pulse_s)
    else $error("factory read strobe not a single pulse");
  ld_finish_a: assert property (!done_r |-> ##[0:20] done_r)
    else $error("factory default load did not finish");
endmodule // rpc_otp_loader
`default_nettype wire

// ===== hdl/rpc_port1_regs.sv
// port-1 configuration and status register set of the dual repeater
//
// Operation
// - bit6 enables host frame-based sleep
// - bit5 enables peripheral frame-based sleep
// - bit4 enables response-based sleep, resets one
// - bit3 picks pin level that requests bridge
// - bit1 picks register or pin bridge source
// - bit0 enables bridge when register sourced
// - bit2 enables D+ pull-up during bridge
// - status bits4-3 report port role
// - status bit0 reports primary detect, inverted
// - tx bits7-6 termination trim, reset 1
// - tx swing bits3-0, chirp amplitude unchanged
// - boost enable bit3, forced off in chirp
// - boost level bits2-0, reset 1
// - boost width bits5-4, reset 3
// - bit6 enables charging method one
// - rx bits7-6 open-drain strength, reset 2
// - strength writable by RAP only repeater enabled
// - rx bits2-0 receive equalizer, reset 2
// - bits7-4 unplug detect level, reset 7
// - bits2-0 signal detect level, reset 4
// - embedded boost level and width fields
// - factory word for register i overrides the default of register i+1, last word its own
`timescale 1ns/1ps
`default_nettype none
`include "rpc_defines.svh"
module rpc_port1_regs (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // i2c target access
  input  wire logic                 i2c_req,
  input  wire logic                 i2c_we,
  input  wire rpc_pkg::rpc_byte_t   i2c_addr,
  input  wire rpc_pkg::rpc_byte_t   i2c_wdata,
  output logic                      i2c_ack,
  // eUSB2 register access protocol
  input  wire logic                 rap_req,
  input  wire logic                 rap_we,
  input  wire rpc_pkg::rpc_byte_t   rap_addr,
  input  wire rpc_pkg::rpc_byte_t   rap_wdata,
  output logic                      rap_ack,
  // shared answer
  output rpc_pkg::rpc_byte_t        rd_data,
  output logic                      addr_err,
  // factory memory
  output logic                      otp_rd,
  output rpc_pkg::rpc_reg_ix_t      otp_ix,
  input  wire rpc_pkg::rpc_byte_t   otp_rdata,
  input  wire logic                 otp_programmed,
  output logic                      cfg_ready,
  // state from the repeater
  input  wire rpc_pkg::rpc_role_t   port_role_in,
  input  wire logic                 chirp_active,
  input  wire logic                 repeater1_enabled,
  input  wire logic                 charge_method_two_enable,
  input  wire logic                 charge_primary_raw,
  input  wire logic                 general_pin_one,
  // settings to the analog front end
  output logic                      host_frame_sleep_enable,
  output logic                      peripheral_frame_sleep_enable,
  output logic                      response_sleep_enable,
  output logic                      bridge_active,
  output logic                      bridge_dplus_pullup,
  output logic [1:0]                usb_termination_trim,
  output logic [1:0]                usb_tx_edge_rate,
  output logic [3:0]                usb_tx_swing,
  output logic                      usb_boost_active,
  output logic [1:0]                usb_boost_width,
  output logic [2:0]                usb_boost_level,
  output logic                      charge_method_one_enable,
  output logic [1:0]                open_drain_strength,
  output logic [2:0]                usb_rx_equalizer,
  output logic [3:0]                unplug_detect_level,
  output logic [2:0]                signal_detect_level,
  output logic [2:0]                embedded_boost_level,
  output logic [1:0]                embedded_boost_width
);
  import rpc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic rpc_reg_ix_t decode_ix(input rpc_byte_t a);
    case (a)
      `RPC_OFF_LOWPWR: decode_ix = RPC_IX_LOWPWR;
      `RPC_OFF_UTX:    decode_ix = RPC_IX_UTX;
      `RPC_OFF_UPE:    decode_ix = RPC_IX_UPE;
      `RPC_OFF_URX:    decode_ix = RPC_IX_URX;
      `RPC_OFF_UDS:    decode_ix = RPC_IX_UDS;
      `RPC_OFF_EPE:    decode_ix = RPC_IX_EPE;
      `RPC_OFF_STATUS: decode_ix = RPC_IX_STATUS;
      default:         decode_ix = RPC_IX_NONE;
    endcase
  endfunction

  function automatic rpc_byte_t wr_mask(input rpc_reg_ix_t ix);
    case (ix)
      RPC_IX_LOWPWR: wr_mask = `RPC_MSK_LOWPWR;
      RPC_IX_UTX:    wr_mask = `RPC_MSK_UTX;
      RPC_IX_UPE:    wr_mask = `RPC_MSK_UPE;
      RPC_IX_URX:    wr_mask = `RPC_MSK_URX;
      RPC_IX_UDS:    wr_mask = `RPC_MSK_UDS;
      RPC_IX_EPE:    wr_mask = `RPC_MSK_EPE;
      default:       wr_mask = 8'h00;
    endcase
  endfunction

  function automatic rpc_byte_t rst_val(input rpc_reg_ix_t ix);
    case (ix)
      RPC_IX_LOWPWR: rst_val = `RPC_RST_LOWPWR;
      RPC_IX_UTX:    rst_val = `RPC_RST_UTX;
      RPC_IX_UPE:    rst_val = `RPC_RST_UPE;
      RPC_IX_URX:    rst_val = `RPC_RST_URX;
      RPC_IX_UDS:    rst_val = `RPC_RST_UDS;
      RPC_IX_EPE:    rst_val = `RPC_RST_EPE;
      default:       rst_val = `RPC_RST_STATUS;
    endcase
  endfunction

  // only masked bits change, reserved bits keep their reset value
  function automatic rpc_byte_t merge(input rpc_byte_t old_v, input rpc_byte_t new_v, input rpc_byte_t m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  rpc_load_if ld ();
  logic [1:0] pins_s;

  rpc_otp_loader u_loader (
    .clk            (clk),
    .arst_n         (arst_n),
    .otp_rd         (otp_rd),
    .otp_ix         (otp_ix),
    .otp_rdata      (otp_rdata),
    .otp_programmed (otp_programmed),
    .ld             (ld.loader)
  );

  rpc_sync #(.W(2)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({charge_primary_raw, general_pin_one}),
    .q      (pins_s)
  );

  wire pin_one_s = pins_s[0];
  wire chg_raw_s = pins_s[1];

  // ----------------------------------------
  // access arbitration
  // ----------------------------------------
  rpc_byte_t   regs_r [0:5];
  logic        i2c_ack_r;
  logic        rap_ack_r;
  rpc_byte_t   rd_data_r;
  logic        addr_err_r;
  rpc_role_t   role_r;
  logic        chg_r;

  // i2c wins a tie, the access protocol waits with its request held
  wire         i2c_take = ld.done && i2c_req && !i2c_ack_r;
  wire         rap_take = ld.done && rap_req && !rap_ack_r && !i2c_take;
  wire         any_take = i2c_take || rap_take;
  wire         acc_we   = i2c_take ? i2c_we    : rap_we;
  wire rpc_byte_t   acc_addr  = i2c_take ? i2c_addr  : rap_addr;
  wire rpc_byte_t   acc_wdata = i2c_take ? i2c_wdata : rap_wdata;
  wire rpc_reg_ix_t acc_ix    = decode_ix(acc_addr);
  wire         acc_hit  = (acc_ix != RPC_IX_NONE);
  wire         acc_reg  = acc_hit && (acc_ix != RPC_IX_STATUS);

  wire         ods_lock = rap_take && (acc_ix == RPC_IX_URX) && !repeater1_enabled;
  wire rpc_byte_t   wmask_eff = wr_mask(acc_ix) & ~(ods_lock ? `RPC_MSK_ODS : 8'h00);
  wire         wr_go    = any_take && acc_we && acc_reg;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // role in status bits
  wire rpc_byte_t status_byte = {3'b000, role_r, 2'b00, chg_r};
  wire rpc_byte_t reg_byte    = acc_reg ? regs_r[acc_ix] : 8'h00;
  wire rpc_byte_t rd_sel      = (acc_ix == RPC_IX_STATUS) ? status_byte : reg_byte;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // factory load then host writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) begin
        regs_r[i] <= rst_val(rpc_reg_ix_t'(i[2:0]));
      end
    end else if (ld.load_we) begin
      regs_r[ld.load_ix] <= merge(regs_r[ld.load_ix], ld.load_data, wr_mask(ld.load_ix));
    end else if (wr_go) begin
      regs_r[acc_ix] <= merge(regs_r[acc_ix], acc_wdata, wmask_eff);
    end
  end

  // ----------------------------------------
  // access answer
  // ----------------------------------------
  // one-cycle ack per source, read data held until next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_ack_r  <= 1'b0;
      rap_ack_r  <= 1'b0;
      rd_data_r  <= 8'h00;
      addr_err_r <= 1'b0;
    end else begin
      i2c_ack_r  <= i2c_take;
      rap_ack_r  <= rap_take;
      addr_err_r <= any_take && !acc_hit;
      if (any_take && !acc_we) begin
        rd_data_r <= rd_sel;
      end
    end
  end

  // ----------------------------------------
  // status capture
  // ----------------------------------------
  // role follows repeater
  // 0 means detected, reads 0 when method off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      role_r <= RPC_ROLE_NONE;
      chg_r  <= 1'b0;
    end else begin
      role_r <= port_role_in;
      chg_r  <= charge_method_two_enable && !chg_raw_s;
    end
  end

  // ----------------------------------------
  // serial bridge and chirp-dependent outputs
  // ----------------------------------------
  wire [7:0] lp_w      = regs_r[RPC_IX_LOWPWR];
  wire       pin_req   = pin_one_s ^ lp_w[`RPC_BR_POL];
  wire       bridge_on = lp_w[`RPC_BR_SRC] ? pin_req : lp_w[`RPC_BR_EN];
  wire [3:0] swing_reg = regs_r[RPC_IX_UTX][`RPC_SWING_LSB +: 4];
  logic       bridge_r;
  logic       pullup_r;
  logic       boost_r;
  logic [3:0] swing_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bridge_r <= 1'b0;
      pullup_r <= 1'b0;
      boost_r  <= 1'b0;
      swing_r  <= `RPC_SWING_NOMINAL;
    end else begin
      bridge_r <= bridge_on;
      pullup_r <= bridge_on && lp_w[`RPC_BR_PU];
      boost_r  <= regs_r[RPC_IX_UPE][`RPC_BEN_BIT] && !chirp_active;
      swing_r  <= chirp_active ? `RPC_SWING_NOMINAL : swing_reg;
    end
  end

  // ----------------------------------------
  // output wiring, all from flops
  // ----------------------------------------
  assign i2c_ack   = i2c_ack_r;
  assign rap_ack   = rap_ack_r;
  assign rd_data   = rd_data_r;
  assign addr_err  = addr_err_r;
  assign cfg_ready = ld.done;
  assign host_frame_sleep_enable       = lp_w[`RPC_LP_HOST];
  assign peripheral_frame_sleep_enable = lp_w[`RPC_LP_PERI];
  assign response_sleep_enable         = lp_w[`RPC_LP_RESP];
  assign bridge_active                 = bridge_r;
  assign bridge_dplus_pullup           = pullup_r;
  assign usb_termination_trim          = regs_r[RPC_IX_UTX][`RPC_TERM_LSB +: 2];
  assign usb_tx_edge_rate              = regs_r[RPC_IX_UTX][`RPC_EDGE_LSB +: 2];
  assign usb_tx_swing                  = swing_r;
  assign usb_boost_active              = boost_r;
  assign usb_boost_width               = regs_r[RPC_IX_UPE][`RPC_BWID_LSB +: 2];
  assign usb_boost_level               = regs_r[RPC_IX_UPE][`RPC_BLVL_LSB +: 3];
  assign charge_method_one_enable      = regs_r[RPC_IX_UPE][`RPC_CHG1_BIT];
  assign open_drain_strength           = regs_r[RPC_IX_URX][`RPC_ODS_LSB +: 2];
  assign usb_rx_equalizer              = regs_r[RPC_IX_URX][`RPC_EQ_LSB +: 3];
  assign unplug_detect_level           = regs_r[RPC_IX_UDS][`RPC_UNPLUG_LSB +: 4];
  assign signal_detect_level           = regs_r[RPC_IX_UDS][`RPC_SIGDET_LSB +: 3];
  assign embedded_boost_level          = regs_r[RPC_IX_EPE][`RPC_EBLVL_LSB +: 3];
  assign embedded_boost_width          = regs_r[RPC_IX_EPE][`RPC_EBWID_LSB +: 2];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence i2c_wr_s(rpc_byte_t a);
    i2c_take && i2c_we && (i2c_addr == a);
  endsequence

  sequence i2c_rd_s(rpc_byte_t a);
    i2c_take && !i2c_we && (i2c_addr == a);
  endsequence

  host_frame_wr_a: assert property (i2c_wr_s(`RPC_OFF_LOWPWR) |=>
      host_frame_sleep_enable == $past(i2c_wdata[`RPC_LP_HOST]))
    else $error("host frame sleep bit not written");
  periph_frame_wr_a: assert property (i2c_wr_s(`RPC_OFF_LOWPWR) |=>
      peripheral_frame_sleep_enable == $past(i2c_wdata[`RPC_LP_PERI]))
    else $error("peripheral frame sleep bit not written");
  resp_sleep_wr_a: assert property (i2c_wr_s(`RPC_OFF_LOWPWR) |=>
      response_sleep_enable == $past(i2c_wdata[`RPC_LP_RESP]))
    else $error("response sleep bit not written");
  bridge_pin_a: assert property (lp_w[`RPC_BR_SRC] |=>
      bridge_active == ($past(pin_one_s) ^ $past(lp_w[`RPC_BR_POL])))
    else $error("bridge does not follow pin with polarity");
  bridge_reg_a: assert property (!lp_w[`RPC_BR_SRC] |=>
      bridge_active == $past(lp_w[`RPC_BR_EN]))
    else $error("bridge does not follow register enable");
  pullup_gate_a: assert property (bridge_dplus_pullup |-> bridge_active)
    else $error("pull-up outside bridge mode");
  role_read_a: assert property (i2c_rd_s(`RPC_OFF_STATUS) |=>
      rd_data[`RPC_ROLE_LSB +: 2] == $past(port_role_in, 2))
    else $error("role status read wrong");
  charge_read_a: assert property (i2c_rd_s(`RPC_OFF_STATUS) |=>
      rd_data[`RPC_CHG_BIT] == ($past(charge_method_two_enable, 2) && !$past(chg_raw_s, 2)))
    else $error("primary detect status read wrong");
  swing_chirp_a: assert property (chirp_active |=> usb_tx_swing == `RPC_SWING_NOMINAL)
    else $error("swing changed during chirp");
  boost_chirp_a: assert property (chirp_active |=> !usb_boost_active)
    else $error("boost active during chirp");
  ods_lock_a: assert property (rap_take && rap_we && (rap_addr == `RPC_OFF_URX)
      && !repeater1_enabled |=> $stable(open_drain_strength))
    else $error("strength written by access protocol while repeater off");
  rsvd_read_a: assert property (i2c_rd_s(`RPC_OFF_URX) |=>
      rd_data[5:3] == `RPC_URX_RSVD)
    else $error("reserved receive bits read wrong");
endmodule // rpc_port1_regs
`default_nettype wire

// ===== verification/rpc_otp_model.sv
// factory memory model answering the default loader
`timescale 1ns/1ps
`default_nettype none
module rpc_otp_model (
  input  wire logic                 clk,
  input  wire logic                 otp_rd,
  input  wire rpc_pkg::rpc_reg_ix_t otp_ix,
  output var rpc_pkg::rpc_byte_t    otp_rdata = 8'h5a,
  output var logic                  otp_programmed = 1'b0
);
  import rpc_pkg::*;
  // answer stands in the cycle after the strobe is seen, garbage otherwise
  always_ff @(posedge clk) begin
    // only the last word is programmed
    if (otp_rd) begin
      otp_rdata      <= 8'hff;
      otp_programmed <= (otp_ix == RPC_IX_EPE);
    end else begin
      otp_rdata      <= ~otp_rdata;
      otp_programmed <= ~otp_programmed;
    end
  end
endmodule // rpc_otp_model
`default_nettype wire

// ===== verification/rpc_port1_regs_test.sv
// self-checking bench for the port-1 register set
`timescale 1ns/1ps
`default_nettype none
module rpc_port1_regs_test;
  import rpc_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0;
  logic        i2c_req = 1'b0, i2c_we = 1'b0, rap_req = 1'b0, rap_we = 1'b0;
  rpc_byte_t   i2c_addr = 8'h00, i2c_wdata = 8'h00, rap_addr = 8'h00, rap_wdata = 8'h00;
  rpc_role_t   port_role_in = RPC_ROLE_NONE;
  logic        chirp_active = 1'b0, repeater1_enabled = 1'b1, charge_method_two_enable = 1'b0;
  logic        charge_primary_raw = 1'b0, general_pin_one = 1'b0;
  wire logic   i2c_ack, rap_ack, addr_err, cfg_ready, otp_rd, otp_programmed;
  wire logic   bridge_active, bridge_dplus_pullup, usb_boost_active;
  wire logic [3:0] usb_tx_swing, unplug_detect_level;
  wire logic   host_frame_sleep_enable, peripheral_frame_sleep_enable, response_sleep_enable;
  wire logic   charge_method_one_enable;
  wire logic [1:0] usb_termination_trim, usb_tx_edge_rate, usb_boost_width, open_drain_strength;
  wire logic [1:0] embedded_boost_width;
  wire logic [2:0] usb_boost_level, usb_rx_equalizer, signal_detect_level, embedded_boost_level;
  // plain setting outputs side by side, 30 bits
  wire logic [31:0] field_w = {2'b00, host_frame_sleep_enable, peripheral_frame_sleep_enable,
    response_sleep_enable, charge_method_one_enable, usb_termination_trim, usb_tx_edge_rate, usb_boost_width,
    usb_boost_level, open_drain_strength, usb_rx_equalizer, unplug_detect_level, signal_detect_level,
    embedded_boost_level, embedded_boost_width};
  // settings after the factory load, only the embedded boost word programmed
  localparam logic [31:0] rst_fields = {2'b00, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1, 2'h3, 2'h3, 3'h1, 2'h2, 3'h2,
    4'h7, 3'h4, 3'h7, 2'h3};
  wire rpc_byte_t  rd_data, otp_rdata;
  wire rpc_reg_ix_t otp_ix;
  int          err_count = 0;
  int          cmp_count = 0;
  rpc_byte_t   offs [7] = '{8'h50, 8'h60, 8'h70, 8'h71, 8'h72, 8'h73, 8'h77};
  rpc_byte_t   rstv [7] = '{8'h50, 8'h00, 8'h77, 8'h39, 8'h92, 8'h74, 8'hf8};
  rpc_byte_t   fullv[7] = '{8'h7f, 8'h00, 8'hff, 8'h7f, 8'hd7, 8'hf7, 8'hf8};

  rpc_port1_regs u_rpc_port1_regs (.*);
  rpc_otp_model u_rpc_otp_model (.clk, .otp_rd, .otp_ix, .otp_rdata, .otp_programmed);

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access: src 0 is i2c, 1 is the eUSB2 path
  task automatic acc(input logic src, input logic we, input rpc_byte_t a, input rpc_byte_t d,
                     input rpc_byte_t exp, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    i2c_we <= we;
    i2c_addr <= a;
    i2c_wdata <= d;
    rap_we <= we;
    rap_addr <= a;
    rap_wdata <= d;
    i2c_req <= !src;
    rap_req <= src;
    do begin
      @(negedge clk);
      n++;
    end while ((src ? rap_ack : i2c_ack) !== 1'b1 && n < 40);
    chk(src ? rap_ack : i2c_ack, 1'b1);
    chk(addr_err, err);
    if (!we) chk(rd_data, exp);
    @(posedge clk);
    i2c_req <= 1'b0;
    rap_req <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk) chk(cfg_ready, 1'b0);
    foreach (offs[i]) acc(1'b0, 1'b0, offs[i], 8'h00, rstv[i], 1'b0);
    @(negedge clk) chk(field_w, rst_fields);
    $display("test reset values done");
    foreach (offs[i]) begin
      acc(1'b0, 1'b1, offs[i], 8'hff, 8'h00, 1'b0);
      acc(1'b1, 1'b0, offs[i], 8'h00, fullv[i], 1'b0);
    end
    acc(1'b0, 1'b0, 8'h55, 8'h00, 8'h00, 1'b1);
    @(negedge clk) chk(field_w, 32'h3fffffff);
    $display("test write all ones done");
    repeat (4) @(negedge clk);
    chk({bridge_active, bridge_dplus_pullup}, 8'h03);
    @(posedge clk) general_pin_one <= 1'b1;
    repeat (4) @(negedge clk);
    chk({bridge_active, bridge_dplus_pullup}, 8'h00);
    acc(1'b0, 1'b1, 8'h50, 8'h01, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    chk({bridge_active, bridge_dplus_pullup}, 8'h02);
    acc(1'b0, 1'b1, 8'h50, 8'h02, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    chk({bridge_active, bridge_dplus_pullup}, 8'h02);
    $display("test bridge done");
    chk({usb_tx_swing, usb_boost_active}, 8'h1f);
    @(posedge clk) chirp_active <= 1'b1;
    repeat (2) @(negedge clk);
    chk({usb_tx_swing, usb_boost_active}, 8'h06);
    @(posedge clk) chirp_active <= 1'b0;
    $display("test chirp done");
    @(posedge clk) repeater1_enabled <= 1'b0;
    acc(1'b1, 1'b1, 8'h72, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 8'h72, 8'h00, 8'hd0, 1'b0);
    acc(1'b0, 1'b1, 8'h72, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 8'h72, 8'h00, 8'h10, 1'b0);
    $display("test strength path done");
    @(posedge clk) port_role_in <= RPC_ROLE_PERIPH;
    charge_method_two_enable <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, 1'b0, 8'h60, 8'h00, 8'h11, 1'b0);
    port_role_in <= RPC_ROLE_HOST;
    charge_primary_raw <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, 1'b0, 8'h60, 8'h00, 8'h08, 1'b0);
    $display("test status done");
    end_of_test();
  end

  // watchdog against a hung handshake
  initial begin
    #20us;
    err_count++;
    end_of_test();
  end
endmodule // rpc_port1_regs_test
`default_nettype wire
